// File: verilog/acs_adc_ctrl.sv
// Serial link and conversion control for an eight-channel 10-bit converter
//
// What this block does
// (R1) Chip select falling starts a conversion in track mode.
// (R2) Any order of chip select fall and clock falls is accepted.
// (R3) First eight rising clock edges of each conversion shift the serial input in.
// (R4) Host sends control bit 7 first, bit 0 on the eighth edge.
// (R5) Channel code latched now selects the input of the next conversion.
// (R6) First conversion after reset comes from input zero but sends a stale word.
// (R7) Control bits seven, six, two, one and zero have no effect.
// (R8) Control bits five to three are the channel index, zero by default.
// (R9) Result is a straight-binary 10-bit code.
// (R10) Powered while chip select is low, powered down while it is high.
// (R11) Back-to-back conversions power down from falling edge 16 to next falling edge 1.
// (R12) Each conversion is sixteen clocks; conversions repeat while select stays low.
// (R13) Host may leave idle gaps between frames to save power.
// (R14) Output four zeros, ten result bits MSB first, two zeros per conversion.
// (R15) Host gives a whole multiple of sixteen rising edges per frame.
// (R16) Output released while select is high; clock ignored while select is high.
// (R17) Track for the first three cycles, hold and convert for thirteen.
`timescale 1ns/1ps
`default_nettype none

module acs_adc_ctrl
  import acs_pkg::*;
#(
  parameter int unsigned RESULT_W = RES_BITS,
  parameter int unsigned CHAN_BITS = CHAN_W
)
(
  input  wire logic                 core_clk_in,
  input  wire logic                 rst_in,
  input  wire logic                 sclk_in,
  input  wire logic                 cs_n_in,
  input  wire logic                 din_in,
  output var  logic                 dout_out,
  output var  logic                 dout_oe_n_out,
  input  wire logic [RESULT_W-1:0]  result_code_in,
  output var  logic [CHAN_BITS-1:0] channel_sel_out,
  output var  logic                 track_out,
  output var  logic                 power_on_out,
  output var  acs_ctl_s             control_word_out,
  output var  logic [RESULT_W-1:0]  result_word_out
);

  // **********************************************************************
  // Functions
  // **********************************************************************

  // Bit presented after the given number of rising edges in a conversion
  function automatic logic frame_bit(input logic [CNT_W-1:0] cnt,
                                     input logic [RESULT_W-1:0] word);
    logic [CNT_W-1:0] idx;
    idx = CNT_RES_LAST - cnt;
    if ((cnt >= CNT_RES_FIRST) && (cnt <= CNT_RES_LAST))
      frame_bit = word[idx]; // R14
    else
      frame_bit = 1'b0; // R14
  endfunction

  // Channel index sits in bits five to three of the control word
  function automatic logic [CHAN_BITS-1:0] chan_of(input acs_ctl_s w);
    chan_of = {w.channel_index_bit2, w.channel_index_bit1, w.channel_index_bit0}; // R8
  endfunction

  // **********************************************************************
  // Link domain, rising edges
  // **********************************************************************
  // Chip select high holds every link flop but word_shadow in its frame-start state, so the
  // gated clock cannot act outside a frame and a new frame always starts
  // cleanly, whatever the clock level when select falls.

  logic [CNT_W-1:0] edge_cnt;
  logic [CNT_W-1:0] next_edge_cnt;
  acs_ctl_s         ctl_shift;
  acs_ctl_s         next_ctl_shift;
  logic             ctl_valid;
  logic             next_ctl_valid;

  always_comb
  begin
    // Wraps after sixteen rises, which opens the next conversion
    next_edge_cnt  = edge_cnt + 4'h1; // R12
    next_ctl_shift = ctl_shift;
    next_ctl_valid = ctl_valid;
    if (edge_cnt <= CNT_CTL_LAST)
    begin
      next_ctl_shift = {ctl_shift[CTL_BITS-2:0], din_in}; // R3 R4
    end
    if (edge_cnt == CNT_CTL_LAST)
    begin
      next_ctl_valid = 1'b1; // R3
    end
    else if (edge_cnt == CNT_CONV_LAST)
    begin
      next_ctl_valid = 1'b0;
    end
  end

  always_ff @(posedge sclk_in or posedge cs_n_in)
  begin
    if (cs_n_in)
    begin
      edge_cnt  <= 4'h0; // R1 R2 R16
      ctl_shift <= CTL_RESET;
      ctl_valid <= 1'b0;
    end
    else
    begin
      edge_cnt  <= next_edge_cnt;
      ctl_shift <= next_ctl_shift;
      ctl_valid <= next_ctl_valid;
    end
  end

  // **********************************************************************
  // Link domain, falling edges
  // **********************************************************************
  // The output bit is chosen from the rising-edge count, so a frame that
  // opens with the clock low (select fall counts as falling edge 1) and one
  // that opens with the clock high present the same bit at each rising edge.
  // Limitation: a conversion sends the code captured in the conversion before
  // it; the core capture and its handshake back outlast the four lead zeros,
  // so the very first conversion after power-up sends a stale word.

  logic                dout_q;
  logic                next_dout_q;
  logic                track_q;
  logic                next_track_q;
  logic                pwr_down_q;
  logic                next_pwr_down_q;
  logic                word_sync1;
  logic                word_sync2;
  logic                word_seen;
  logic                next_word_seen;
  logic [RESULT_W-1:0] word_shadow;
  logic [RESULT_W-1:0] next_word_shadow;
  logic [RESULT_W-1:0] word_out;
  logic [RESULT_W-1:0] next_word_out;
  logic                core_word_tgl;
  logic [RESULT_W-1:0] core_word;

  always_comb
  begin
    next_word_seen   = word_seen;
    next_word_shadow = word_shadow;
    if (word_sync2 != word_seen)
    begin
      next_word_seen   = word_sync2;
      next_word_shadow = core_word;
    end
    next_word_out = word_out;
    if (edge_cnt == CNT_RES_FIRST)
    begin
      next_word_out = word_shadow; // R14
    end
    next_dout_q     = frame_bit(edge_cnt, next_word_out); // R14
    next_track_q    = (edge_cnt < CNT_TRACK_END); // R17
    next_pwr_down_q = (edge_cnt == CNT_CONV_LAST); // R11
  end

  always_ff @(negedge sclk_in or posedge cs_n_in)
  begin
    if (cs_n_in)
    begin
      dout_q     <= 1'b0; // R14
      track_q    <= 1'b1; // R1
      pwr_down_q <= 1'b0;
      word_sync1 <= 1'b0;
      word_sync2 <= 1'b0;
      word_seen  <= 1'b0;
      word_out   <= RESULT_RESET;
    end
    else
    begin
      dout_q     <= next_dout_q;
      track_q    <= next_track_q;
      pwr_down_q <= next_pwr_down_q;
      word_sync1 <= core_word_tgl;
      word_sync2 <= word_sync1;
      word_seen  <= next_word_seen;
      word_out   <= next_word_out;
    end
  end

  // Shadow must survive between frames, so select does not clear it
  always_ff @(negedge sclk_in)
  begin
    word_shadow <= next_word_shadow;
  end

  assign dout_out      = dout_q;
  // Enable is select itself, not a flop: a registered copy would leave the pin
  // undriven until the first clock edge of a frame
  assign dout_oe_n_out = cs_n_in; // R16

  acs_stat_s link_stat;

  always_comb
  begin
    link_stat.pwr_down  = pwr_down_q;
    link_stat.track     = track_q;
    link_stat.ctl_valid = ctl_valid;
  end

  // **********************************************************************
  // Core domain, synchronisers
  // **********************************************************************
  // Status bits are levels that stand for at least three link clocks, apart
  // from the power-down pulse, which stands for one. A fast link clock may
  // slip that pulse past these flops; the core then steps from hold straight
  // back to track and stays powered, which costs power, not data.

  logic      cs_sync1;
  logic      cs_sync2;
  acs_stat_s stat_sync1;
  acs_stat_s stat_sync2;

  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
    begin
      cs_sync1   <= 1'b1;
      cs_sync2   <= 1'b1;
      stat_sync1 <= STAT_IDLE;
      stat_sync2 <= STAT_IDLE;
    end
    else
    begin
      cs_sync1   <= cs_n_in;
      cs_sync2   <= cs_sync1;
      stat_sync1 <= link_stat;
      stat_sync2 <= stat_sync1;
    end
  end

  // **********************************************************************
  // Core domain, phase and channel control
  // **********************************************************************
  // The control word is read straight from the link shift register only on
  // the rise of its synchronised valid level; it stays still from the eighth
  // rising edge until the next conversion, far longer than the sync delay.

  acs_phase_e          phase;
  acs_phase_e          next_phase;
  logic                valid_prev;
  logic [CHAN_BITS-1:0] chan;
  logic [CHAN_BITS-1:0] next_chan;
  acs_ctl_s            ctl_word;
  acs_ctl_s            next_ctl_word;
  logic [RESULT_W-1:0] next_core_word;
  logic                next_core_word_tgl;
  logic                track_flag;
  logic                next_track_flag;
  logic                power_flag;
  logic                next_power_flag;

  always_comb
  begin
    next_phase = phase;
    unique case (phase)
      PH_OFF:
      begin
        if (!cs_sync2 && !stat_sync2.pwr_down)
          next_phase = stat_sync2.track ? PH_TRACK : PH_HOLD; // R1 R10
      end
      PH_TRACK:
      begin
        if (cs_sync2)
          next_phase = PH_OFF; // R10
        else if (!stat_sync2.track)
          next_phase = PH_HOLD; // R17
      end
      PH_HOLD:
      begin
        if (cs_sync2 || stat_sync2.pwr_down)
          next_phase = PH_OFF; // R10 R11
        else if (stat_sync2.track)
          next_phase = PH_TRACK; // R12 R17
      end
    endcase

    // Registered copies of the coming phase keep the outputs flop-driven
    // without a cycle of extra latency
    next_track_flag = (next_phase == PH_TRACK); // R17
    next_power_flag = (next_phase != PH_OFF); // R10

    next_chan     = chan;
    next_ctl_word = ctl_word;
    if (stat_sync2.ctl_valid && !valid_prev)
    begin
      next_ctl_word = ctl_shift;
      next_chan     = chan_of(ctl_shift); // R5 R7 R8
    end

    next_core_word     = core_word;
    next_core_word_tgl = core_word_tgl;
    if ((phase == PH_TRACK) && (next_phase == PH_HOLD))
    begin
      next_core_word     = result_code_in; // R9
      next_core_word_tgl = ~core_word_tgl;
    end
  end

  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
    begin
      phase         <= PH_OFF;
      valid_prev    <= 1'b0;
      chan          <= CHAN_RESET; // R6 R8
      ctl_word      <= CTL_RESET;
      core_word     <= RESULT_RESET;
      core_word_tgl <= 1'b0;
      track_flag    <= 1'b0;
      power_flag    <= 1'b0;
    end
    else
    begin
      phase         <= next_phase;
      valid_prev    <= stat_sync2.ctl_valid;
      chan          <= next_chan;
      ctl_word      <= next_ctl_word;
      core_word     <= next_core_word;
      core_word_tgl <= next_core_word_tgl;
      track_flag    <= next_track_flag;
      power_flag    <= next_power_flag;
    end
  end

  // **********************************************************************
  // Core domain outputs
  // **********************************************************************

  assign channel_sel_out  = chan;
  assign track_out        = track_flag;
  assign power_on_out     = power_flag; // R10
  assign control_word_out = ctl_word;
  assign result_word_out  = core_word;

endmodule

`default_nettype wire

// File: verilog/acs_pkg.sv
// Shared constants and types for the channel-select serial control block
`default_nettype none

package acs_pkg;

  // **********************************************************************
  // Conversion frame layout, counted in serial clock cycles
  // **********************************************************************
  localparam int unsigned CONV_CYCLES  = 16;
  localparam int unsigned TRACK_CYCLES = 3;
  localparam int unsigned CTL_BITS     = 8;
  localparam int unsigned LEAD_ZEROS   = 4;
  localparam int unsigned RES_BITS     = 10;
  localparam int unsigned CNT_W        = 4;

  // Rising-edge count at which each frame event falls
  localparam logic [3:0] CNT_CTL_LAST  = 4'h7;
  localparam logic [3:0] CNT_RES_FIRST = 4'h4;
  localparam logic [3:0] CNT_RES_LAST  = 4'hd;
  localparam logic [3:0] CNT_TRACK_END = 4'h3;
  localparam logic [3:0] CNT_CONV_LAST = 4'hf;

  // **********************************************************************
  // Control word field layout and reset values
  // **********************************************************************
  localparam int unsigned CHAN_LSB     = 3;
  localparam int unsigned CHAN_W       = 3;
  localparam logic [2:0]  CHAN_RESET   = 3'h0;
  localparam logic [7:0]  CTL_RESET    = 8'h00;
  localparam logic [9:0]  RESULT_RESET = 10'h000;

  typedef struct packed {
    logic [1:0] ignored_bit_hi;
    logic       channel_index_bit2;
    logic       channel_index_bit1;
    logic       channel_index_bit0;
    logic [2:0] ignored_bit_lo;
  } acs_ctl_s;

  // Levels handed from the link domain to the core domain
  typedef struct packed {
    logic pwr_down;
    logic track;
    logic ctl_valid;
  } acs_stat_s;

  localparam acs_stat_s STAT_IDLE = 3'h2;

  // Converter phase seen from the core domain
  typedef enum logic [2:0] {
    PH_OFF   = 3'b001,
    PH_TRACK = 3'b010,
    PH_HOLD  = 3'b100
  } acs_phase_e;

endpackage

`default_nettype wire

// File: verification/acs_adc_ctrl_checker.sv
// Port checker for the channel-select serial control block
`timescale 1ns/1ps
`default_nettype none
module acs_adc_ctrl_checker
  import acs_pkg::*;
(
  input wire logic       core_clk_in,
  input wire logic       rst_in,
  input wire logic       sclk_in,
  input wire logic       cs_n_in,
  input wire logic       dout_out,
  input wire logic       dout_oe_n_out,
  input wire logic [9:0] result_code_in,
  input wire logic [2:0] channel_sel_out,
  input wire logic       track_out,
  input wire logic       power_on_out,
  input wire acs_ctl_s   control_word_out,
  input wire logic [9:0] result_word_out
);
  // ****
  // Rising-edge position within a conversion
  // ****
  logic [3:0] pos;
  logic [3:0] next_pos;
  always_comb next_pos = pos + 4'h1;
  // Cleared by select high, like the link side itself
  always_ff @(posedge sclk_in or posedge cs_n_in)
  begin
    if (cs_n_in)
      pos <= 4'h0;
    else
      pos <= next_pos;
  end
  oe_is_select_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    dout_oe_n_out == cs_n_in) else $error("output enable differs from select");
  dout_idle_low_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    cs_n_in |-> !dout_out) else $error("serial output active while deselected");
  chan_from_word_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    $changed(control_word_out) |-> ##[0:3] channel_sel_out == control_word_out[5:3])
    else $error("channel select does not follow bits five to three");
  track_powered_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    track_out |-> power_on_out) else $error("tracking while powered down");
  off_when_high_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    cs_n_in [*5] |-> !power_on_out) else $error("powered while deselected");
  start_tracks_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    $rose(power_on_out) |-> track_out) else $error("conversion did not start in track");
  hold_captures_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    $fell(track_out) && power_on_out |-> ##[0:2] result_word_out == result_code_in)
    else $error("hold did not capture the result");
  pad_zeros_a: assert property (@(posedge sclk_in) disable iff (cs_n_in)
    (pos < 4'h4 || pos > 4'hd) |-> !dout_out) else $error("pad bit not zero");
endmodule
bind acs_adc_ctrl acs_adc_ctrl_checker acs_adc_ctrl_checker_i (.core_clk_in(core_clk_in),
  .rst_in(rst_in), .sclk_in(sclk_in), .cs_n_in(cs_n_in), .dout_out(dout_out),
  .dout_oe_n_out(dout_oe_n_out), .result_code_in(result_code_in), .channel_sel_out(channel_sel_out),
  .track_out(track_out), .power_on_out(power_on_out), .control_word_out(control_word_out),
  .result_word_out(result_word_out));
`default_nettype wire

// File: verification/acs_host_model.sv
// Serial host model: frames, clocks and control words
`timescale 1ns/1ps
`default_nettype none
module acs_host_model (
  output var  logic sclk_out,
  output var  logic cs_n_out,
  output var  logic din_out,
  input  wire logic dout_in
);
  // ****
  // Frame tasks; clock stands still outside them, except while noise toggles it with select high
  // ****
  initial
  begin
    sclk_out = 1'b0;
    cs_n_out = 1'b0;
    din_out = 1'b0;
    // A real rise after time zero, so the link side surely sees its clear
    #1 cs_n_out = 1'b1;
  end
  // Mode 0: select falls with clock low; 1: with clock high; 2: both together
  task automatic open(input logic [1:0] mode);
    if (mode != 2'h0)
    begin
      sclk_out = 1'b1;
      #3 cs_n_out = 1'b0;
      if (mode == 2'h2)
        sclk_out = 1'b0;
      else
        #3 sclk_out = 1'b0;
    end
    else
      #3 cs_n_out = 1'b0;
  endtask
  // Bits past the word toggle so a stale level is never mistaken for data
  task automatic conv(input logic [7:0] ctl, output logic [15:0] rx);
    for (int i = 0; i < 16; i++)
    begin
      din_out = (i < 8) ? ctl[7 - i] : ~din_out;
      #3 sclk_out = 1'b1;
      rx = {rx[14:0], dout_in};
      #3 sclk_out = 1'b0;
    end
  endtask
  task automatic close();
    #3 cs_n_out = 1'b1;
    din_out = ~din_out;
  endtask
  task automatic noise();
    repeat (20)
    begin
      #3 sclk_out = ~sclk_out;
      din_out = ~din_out;
    end
  endtask
endmodule
`default_nettype wire

// File: verification/test_acs_adc_ctrl.sv
// Testbench for the channel-select serial control block
`timescale 1ns/1ps
`default_nettype none
module test_acs_adc_ctrl;
  // ****
  // Bench signals and helpers
  // ****
  logic              core_clk_in = 1'b0;
  logic              rst_in = 1'b1;
  logic [9:0]        code = 10'h000;
  wire               sclk, cs_n, din, dout, dout_oe_n, track, pwr_on;
  wire [2:0]         chan;
  wire [9:0]         res_word;
  acs_pkg::acs_ctl_s ctl_word;
  int                fail_count = 0;
  int                n_checks = 0;
  logic [15:0]       rx;
  logic [7:0]        ctl;
  always #4 core_clk_in = ~core_clk_in;
  acs_adc_ctrl acs_adc_ctrl_i (.core_clk_in(core_clk_in), .rst_in(rst_in), .sclk_in(sclk), .cs_n_in(cs_n),
    .din_in(din), .dout_out(dout), .dout_oe_n_out(dout_oe_n), .result_code_in(code), .channel_sel_out(chan),
    .track_out(track), .power_on_out(pwr_on), .control_word_out(ctl_word), .result_word_out(res_word));
  acs_host_model acs_host_model_i (.sclk_out(sclk), .cs_n_out(cs_n), .din_out(din), .dout_in(dout));
  task check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      $display("BAD %s expected %h seen %h", name, exp, seen);
      fail_count++;
    end
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task core_wait(input int n);
    repeat (n) @(negedge core_clk_in);
  endtask
  // ****
  // Main sequence
  // ****
  initial
  begin
    repeat (12) @(negedge core_clk_in);
    rst_in = 1'b0;
    core_wait(3);
    check("reset", {ctl_word, chan, pwr_on}, 16'h0000);
    for (int lead = 0; lead < 3; lead++)
    begin
      code = lead[0] ? 10'h2a5 : 10'h35a;
      acs_host_model_i.open(lead[1:0]);
      core_wait(5);
      check("track", {track, pwr_on, dout_oe_n}, 16'h0006);
      for (int c = 0; c < 8; c++)
      begin
        ctl = c[0] ? {2'h3, c[2:0], 3'h7} : {2'h0, c[2:0], 3'h0};
        acs_host_model_i.conv(ctl, rx);
        check("pad", {rx[15:12], rx[1:0]}, 16'h0000);
        // First word of a frame carries the code captured before it
        if (c > 0)
          check("result", rx[11:2], code);
        core_wait(4);
        check("chan", chan, c[2:0]);
        check("ctl", ctl_word, ctl);
        check("res_word", res_word, code);
      end
      for (int i = 0; i < 3; i++)
      begin
        acs_host_model_i.conv(8'h28, rx);
        check("burst", rx, {4'h0, code, 2'h0});
      end
      acs_host_model_i.close();
      for (int i = 0; i < 10 && pwr_on !== 1'b0; i++)
        core_wait(1);
      check("off", {pwr_on, dout_oe_n, dout}, 16'h0002);
      acs_host_model_i.noise();
      core_wait(4);
      check("ignored", {ctl_word, chan, pwr_on}, {4'h0, 8'h28, 3'h5, 1'b0});
      $display("test frame %0d done", lead);
    end
    end_of_test;
  end
  initial
  begin
    #200000;
    fail_count++;
    end_of_test;
  end
endmodule
`default_nettype wire
